//--- sgl_defines.vh
`ifndef SGL_DEFINES_VH
`define SGL_DEFINES_VH

// ----------------------------------------------------------------
// word layout
// ----------------------------------------------------------------
`define SGL_WORD_BITS 8
`define SGL_MSB 7
`define SGL_CNT_BITS 4
`define SGL_CNT_FULL 4'h8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SGL_GAIN_RST 8'h00
`define SGL_FRAME_IDLE 1'b1
`define SGL_CLK_IDLE 1'b0

// ----------------------------------------------------------------
// gain scale, hundredths of a dB, two's complement
// ----------------------------------------------------------------
`define SGL_GAIN_BASE_CDB 16'hF8E8
`define SGL_GAIN_STEP_CDB 16'h025A
`define SGL_STEP_BITS 4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SGL_SYNC_STAGES 3
`define SGL_CLK_SYS_NS 50
`define SGL_LINK_CLK_NS 400
`define SGL_LINK_HALF_CYC (`SGL_LINK_CLK_NS / 2 / `SGL_CLK_SYS_NS)

`endif

//--- sgl_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// host side: frame, 400 ns shift clock idle low, data
// ----------------------------------------------------------------
module sgl_host_model (
    input wire clk_sys,
    output reg shift_clk,
    output reg frame_enable_low,
    output reg serial_gain_in,
    output reg transmit_gate
);
    initial begin
        shift_clk = 1'b0;
        frame_enable_low = 1'b1;
        serial_gain_in = 1'b0;
        transmit_gate = 1'b0;
    end
    task automatic half;
        repeat (4) @(negedge clk_sys);
    endtask
    // en low sends clocks with the frame left high
    task automatic send(input logic [15:0] w, input int n, input logic en);
        int i;
        frame_enable_low = !en;
        half;
        for (i = n - 1; i >= 0; i--) begin
            serial_gain_in = w[i];
            half;
            shift_clk = 1'b1;
            half;
            shift_clk = 1'b0;
        end
        half;
        frame_enable_low = 1'b1;
        // released data line shows no stale bit
        serial_gain_in = !serial_gain_in;
    endtask
endmodule

//--- sgl_loader.v
`timescale 1ns/1ps
`include "sgl_defines.vh"

// Rules this block works to; RL1 and RL10 bind the host, which the block only flags or observes
// [RL1] host shifts full eight-bit word per change
// [RL2] frame-enable falling edge opens serial loading
// [RL3] rising shift clock captures data, MSB first
// [RL4] frame-enable rising edge applies word to core
// [RL5] code zero -18.16 dB, 6.02 dB steps
// [RL6] single-bit codes map onto listed gain values
// [RL7] rise latches master, fall moves to slave
// [RL8] frame high inhibits shifting; low holds gain
// [RL9] gain starts at code zero after power-up
// [RL10] host keeps transmit gate low until programmed
// [RL11] extra clocks: last eight bits win
module sgl_loader #(
    parameter WORD_BITS = `SGL_WORD_BITS
) (
    input wire clk_sys,
    input wire rst_n,
    input wire shift_clk,
    input wire frame_enable_low,
    input wire serial_gain_in,
    input wire transmit_gate,
    output wire [WORD_BITS-1:0] gain_code,
    output wire gain_update,
    output wire [15:0] gain_centidb,
    output wire loading,
    output wire [`SGL_CNT_BITS-1:0] bits_seen,
    output wire word_short,
    output wire tx_enabled
);

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    // bit order: 3 clk, 2 frame, 1 data, 0 gate
    wire [3:0] pins_in;
    wire [3:0] s2;
    wire [3:0] s3;

    assign pins_in = {shift_clk, frame_enable_low, serial_gain_in, transmit_gate};

    sgl_sync #(
        .WIDTH(4),
        .INIT({`SGL_CLK_IDLE, `SGL_FRAME_IDLE, 1'b0, 1'b0})
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in(pins_in),
        .stage2(s2),
        .stage3(s3)
    );

    // ----------------------------------------------------------------
    // agreement filter: a level counts once stages two and three agree
    // ----------------------------------------------------------------
    reg [3:0] lvl_r;
    wire [3:0] lvl_nxt;
    reg [3:0] prev_r;

    // a bit that is still settling keeps its old level
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_agree
            assign lvl_nxt[g] = (s2[g] == s3[g]) ? s3[g] : lvl_r[g];
        end
    endgenerate

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lvl_r <= {`SGL_CLK_IDLE, `SGL_FRAME_IDLE, 1'b0, 1'b0};
            prev_r <= {`SGL_CLK_IDLE, `SGL_FRAME_IDLE, 1'b0, 1'b0};
        end else begin
            lvl_r <= lvl_nxt;
            prev_r <= lvl_r;
        end
    end

    wire clk_lvl;
    wire frame_lvl;
    wire data_lvl;
    wire clk_rise;
    wire clk_fall;
    wire frame_fall;
    wire frame_rise;

    assign clk_lvl = lvl_r[3];
    assign frame_lvl = lvl_r[2];
    assign data_lvl = lvl_r[1];
    assign clk_rise = clk_lvl & ~prev_r[3];
    assign clk_fall = ~clk_lvl & prev_r[3];
    assign frame_fall = ~frame_lvl & prev_r[2];
    assign frame_rise = frame_lvl & ~prev_r[2];

    // ----------------------------------------------------------------
    // frame tracking
    // ----------------------------------------------------------------
    // clock edges only count while the frame is open
    wire shift_ok;
    assign shift_ok = ~frame_lvl; // [RL2] [RL8]

    reg [`SGL_CNT_BITS-1:0] cnt_r;
    reg [`SGL_CNT_BITS-1:0] cnt_nxt;

    always @* begin
        cnt_nxt = cnt_r;
        if (frame_fall) begin
            cnt_nxt = {`SGL_CNT_BITS{1'b0}};
        end else if (shift_ok && clk_rise && cnt_r != `SGL_CNT_FULL) begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= {`SGL_CNT_BITS{1'b0}};
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // ----------------------------------------------------------------
    // master-slave shift register
    // ----------------------------------------------------------------
    reg [WORD_BITS-1:0] master_r;
    reg [WORD_BITS-1:0] master_nxt;
    reg [WORD_BITS-1:0] slave_r;
    reg [WORD_BITS-1:0] slave_nxt;

    always @* begin
        master_nxt = master_r;
        slave_nxt = slave_r;
        if (shift_ok && clk_rise) begin
            // oldest bit falls off the top, so surplus clocks keep the last eight
            master_nxt = {master_r[WORD_BITS-2:0], data_lvl}; // [RL3] [RL7] [RL11]
        end
        if (shift_ok && clk_fall) begin
            slave_nxt = master_r; // [RL7]
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            master_r <= {WORD_BITS{1'b0}};
            slave_r <= {WORD_BITS{1'b0}};
        end else begin
            master_r <= master_nxt;
            slave_r <= slave_nxt;
        end
    end

    // ----------------------------------------------------------------
    // gain latch
    // ----------------------------------------------------------------
    reg [WORD_BITS-1:0] gain_r;
    reg upd_r;
    reg short_r;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gain_r <= `SGL_GAIN_RST; // [RL9]
            upd_r <= 1'b0;
            short_r <= 1'b0;
        end else begin
            upd_r <= frame_rise;
            if (frame_rise) begin
                // a short frame is still applied; the flag only reports it
                gain_r <= slave_r; // [RL4] [RL8]
                short_r <= (cnt_r != `SGL_CNT_FULL); // [RL1]
            end
        end
    end

    // ----------------------------------------------------------------
    // gain in hundredths of a dB from the highest set bit
    // ----------------------------------------------------------------
    // mixed codes are reported at their top bit; finer weighting is analogue
    reg [`SGL_STEP_BITS-1:0] step_c;
    integer k;

    always @* begin
        step_c = {`SGL_STEP_BITS{1'b0}};
        for (k = 0; k < WORD_BITS; k = k + 1) begin
            if (gain_r[k]) begin
                step_c = k[`SGL_STEP_BITS-1:0] + 1'b1;
            end
        end
    end

    reg [15:0] cdb_r;
    wire [15:0] step_wide;
    wire [15:0] step_prod;

    assign step_wide = {{(16 - `SGL_STEP_BITS){1'b0}}, step_c};
    assign step_prod = step_wide * `SGL_GAIN_STEP_CDB;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cdb_r <= `SGL_GAIN_BASE_CDB;
        end else begin
            cdb_r <= `SGL_GAIN_BASE_CDB + step_prod; // [RL5] [RL6]
        end
    end

    // ----------------------------------------------------------------
    // transmit gate
    // ----------------------------------------------------------------
    // only observed; the host orders gate against programming
    reg tx_r;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_r <= 1'b0;
        end else begin
            tx_r <= lvl_r[0]; // [RL10]
        end
    end

    reg load_r;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            load_r <= 1'b0;
        end else begin
            load_r <= shift_ok;
        end
    end

    assign gain_code = gain_r;
    assign gain_update = upd_r;
    assign gain_centidb = cdb_r;
    assign loading = load_r;
    assign bits_seen = cnt_r;
    assign word_short = short_r;
    assign tx_enabled = tx_r;

endmodule

//--- sgl_loader_chk.sv
`timescale 1ns/1ps
`include "sgl_defines.vh"

// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module sgl_loader_chk #(
    parameter WORD_BITS = 8
) (
    input wire clk_sys,
    input wire rst_n,
    input wire shift_clk,
    input wire frame_enable_low,
    input wire serial_gain_in,
    input wire transmit_gate,
    input wire [WORD_BITS-1:0] gain_code,
    input wire gain_update,
    input wire [15:0] gain_centidb,
    input wire loading,
    input wire [`SGL_CNT_BITS-1:0] bits_seen,
    input wire word_short,
    input wire tx_enabled
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    code_by_update_a: assert property ($changed(gain_code) |-> gain_update)
        else $error("code moved without update");
    update_pulse_a: assert property (gain_update |=> !gain_update)
        else $error("update longer than one cycle");
    hold_in_frame_a: assert property (loading |-> !gain_update)
        else $error("update inside frame");
    gain_zero_a: assert property (gain_update && gain_code == 8'h00 |=> gain_centidb == 16'hF8E8)
        else $error("code zero gain wrong");
    gain_top_a: assert property (gain_update && gain_code == 8'h80 |=> gain_centidb == 16'h0BB8)
        else $error("top code gain wrong");
    count_cap_a: assert property (bits_seen <= 4'h8)
        else $error("count above eight");
    count_step_a: assert property (loading && $past(loading) && $changed(bits_seen)
        |-> bits_seen == $past(bits_seen) + 4'h1)
        else $error("count skipped");
    idle_count_a: assert property (!loading |-> $stable(bits_seen))
        else $error("count moved outside frame");
    gate_follow_a: assert property ($rose(transmit_gate) |-> ##[1:6] tx_enabled)
        else $error("gate not followed");
    frame_open_a: assert property ($fell(frame_enable_low) |-> ##[4:6] loading)
        else $error("frame fall not seen");
    cover property (gain_update && word_short);
    cover property (bits_seen == 4'h8 && loading);
    cover property (gain_update && gain_code == 8'h80);
endmodule

bind sgl_loader sgl_loader_chk #(.WORD_BITS(WORD_BITS)) i_chk (.clk_sys(clk_sys),
    .rst_n(rst_n), .shift_clk(shift_clk), .frame_enable_low(frame_enable_low),
    .serial_gain_in(serial_gain_in), .transmit_gate(transmit_gate), .gain_code(gain_code),
    .gain_update(gain_update), .gain_centidb(gain_centidb), .loading(loading),
    .bits_seen(bits_seen), .word_short(word_short), .tx_enabled(tx_enabled));

//--- sgl_sync.v
`timescale 1ns/1ps
`include "sgl_defines.vh"

// ----------------------------------------------------------------
// three-stage input synchroniser, stage one feeds stage two only
// ----------------------------------------------------------------
module sgl_sync #(
    parameter WIDTH = 4,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] stage2,
    output wire [WIDTH-1:0] stage3
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] stage2_r;
    reg [WIDTH-1:0] stage3_r;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= INIT;
            stage2_r <= INIT;
            stage3_r <= INIT;
        end else begin
            meta_r <= async_in;
            stage2_r <= meta_r;
            stage3_r <= stage2_r;
        end
    end

    assign stage2 = stage2_r;
    assign stage3 = stage3_r;

endmodule

//--- testbench.sv
`timescale 1ns/1ps

module testbench;
    reg clk_sys = 1'b0;
    reg rst_n = 1'b0;
    wire shift_clk, frame_enable_low, serial_gain_in, transmit_gate;
    wire [7:0] gain_code;
    wire [15:0] gain_centidb;
    wire [3:0] bits_seen;
    wire gain_update, loading, word_short, tx_enabled;
    int fail_count = 0;
    int comparisons = 0;
    logic [7:0] sr = 8'h00;
    int k;
    always #25 clk_sys = ~clk_sys;
    sgl_loader #(.WORD_BITS(8)) i_sgl_loader (.clk_sys(clk_sys), .rst_n(rst_n),
        .shift_clk(shift_clk), .frame_enable_low(frame_enable_low),
        .serial_gain_in(serial_gain_in), .transmit_gate(transmit_gate),
        .gain_code(gain_code), .gain_update(gain_update), .gain_centidb(gain_centidb),
        .loading(loading), .bits_seen(bits_seen), .word_short(word_short),
        .tx_enabled(tx_enabled));
    sgl_host_model host (.clk_sys(clk_sys), .shift_clk(shift_clk),
        .frame_enable_low(frame_enable_low), .serial_gain_in(serial_gain_in),
        .transmit_gate(transmit_gate));
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [15:0] cdb(input logic [7:0] c);
        int i;
        cdb = 16'hF8E8;
        for (i = 0; i < 8; i++) if (c[i]) cdb = 16'hF8E8 + 16'(16'h025A * (i + 1));
    endfunction
    task automatic frame(input logic [15:0] w, input int n, input logic en);
        int i, t;
        logic hit;
        host.send(w, n, en);
        if (en) for (i = n - 1; i >= 0; i--) sr = {sr[6:0], w[i]};
        hit = 1'b0;
        for (t = 0; t < 12 && !hit; t++) begin
            @(posedge clk_sys);
            #1;
            hit = (gain_update === 1'b1);
        end
        check(16'(hit), 16'(en), "update");
        check(16'(gain_code), 16'(sr), "code");
        if (en) check(16'(bits_seen), (n > 8) ? 16'h0008 : 16'(n), "count");
        if (en) check(16'(word_short), 16'(n < 8), "short");
        @(posedge clk_sys);
        #1;
        check(gain_centidb, cdb(sr), "gain");
        check(16'(tx_enabled), 16'(transmit_gate), "gate");
        check(16'(loading), 16'h0000, "loading");
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        fail_count++;
        tally_and_finish;
    end
    initial begin
        k = $urandom(32'h478F);
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (5) @(negedge clk_sys);
        check(16'(gain_code), 16'h0000, "power-up code");
        check(gain_centidb, 16'hF8E8, "power-up gain");
        $display("done: power-up");
        for (k = 0; k < 8; k++) frame(16'h0001 << k, 8, 1'b1);
        host.transmit_gate = 1'b1;
        frame(16'h0000, 8, 1'b1);
        $display("done: single bits");
        frame(16'h00A5, 8, 1'b0);
        frame(16'h03C5, 10, 1'b1);
        frame(16'h0005, 3, 1'b1);
        $display("done: odd frames");
        repeat (20) begin
            host.transmit_gate = 1'($urandom);
            frame(16'($urandom), 5 + ($urandom % 6), 1'b1);
        end
        $display("done: random frames");
        // reset in mid-run must drop the applied gain back to code zero
        rst_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        sr = 8'h00;
        repeat (5) @(negedge clk_sys);
        check(16'(gain_code), 16'h0000, "reset code");
        check(gain_centidb, 16'hF8E8, "reset gain");
        frame(16'h0006, 3, 1'b1);
        $display("done: mid-run reset");
        tally_and_finish;
    end
endmodule
